// >>> verilog/swdt_pkg.sv
// package: register layout, reset values and timing counts of the supervisory timer
package swdt_pkg;
  // apb register map (byte addresses)
  localparam logic [11:0] SWDT_COUNT_OFS = 12'h000; // supervisor_count_register
  localparam logic [11:0] SWDT_CFG_OFS = 12'h004; // option straps readback / stop status
  localparam logic [11:0] SWDT_STAT_OFS = 12'h008; // raw counter and state readback
  // field positions of the count register
  localparam int SWDT_ACT_BIT = 0; // activate bit
  localparam int SWDT_SRST_BIT = 1; // soft_reset_bit
  localparam int SWDT_CNT_LSB = 2; // lowest register bit of the count field
  localparam int SWDT_CNT_W = 6; // count bits
  localparam int SWDT_TMR_W = 7; // count bits plus soft-reset bit
  // reset value of the count register
  localparam logic [7:0] SWDT_RESET_VAL = 8'hFE;
  // step interval in oscillator clocks
  localparam int SWDT_STEP_CLKS = 3072;
  // reference step time at 8 MHz, in microseconds
  localparam int SWDT_STEP_US_8MHZ = 384;
  // clock period in ps and reset pulse length in ns
  localparam int SWDT_CLK_PS = 4000;
  localparam int SWDT_RST_PULSE_NS = 500;
  // reset pulse in clocks: longest time, rounded down, at least one
  localparam int SWDT_RST_PULSE_CLKS_RAW = (SWDT_RST_PULSE_NS * 1000) / SWDT_CLK_PS;
  localparam int SWDT_RST_PULSE_CLKS =
    (SWDT_RST_PULSE_CLKS_RAW < 1) ? 1 : SWDT_RST_PULSE_CLKS_RAW;
  // power modes seen by the core
  typedef enum logic [1:0] {
    SWDT_RUN = 2'b00,
    SWDT_WAIT = 2'b01,
    SWDT_STOP = 2'b10
  } swdt_mode_t;
endpackage

// >>> verilog/swdt_sync.sv
// three-flop synchroniser with agreement filter for a pin input
`timescale 1ns/100ps
module swdt_sync (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic pinIn,
  output logic pinOut
);
  logic [2:0] stage_reg; // shift chain, stage 0 read only by stage 1
  // shift the pin through three flops
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stage_reg <= 3'h0;
    end else begin
      stage_reg <= {stage_reg[1:0], pinIn};
    end
  end
  // accept a change only once the second and third agree
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pinOut <= 1'b0;
    end else if (stage_reg[1] == stage_reg[2]) begin
      pinOut <= stage_reg[2];
    end
  end
endmodule // swdt_sync

// >>> verilog/swdt_prescale.sv
// step prescaler: one tick every STEP_CLKS clocks, restartable, freezable
`timescale 1ns/100ps
module swdt_prescale #(
  parameter int STEP_CLKS = 3072
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic restart,
  input wire logic freeze,
  output logic tick
);
  localparam int CW = $clog2(STEP_CLKS);
  localparam logic [CW-1:0] LAST = CW'(STEP_CLKS - 1);
  logic [CW-1:0] div_reg; // clocks elapsed in the current step
  initial begin
    if (STEP_CLKS < 2) $error("swdt_prescale: STEP_CLKS must be at least 2");
  end
  // count clocks; a restart begins a fresh interval, a freeze holds it
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      div_reg <= '0;
    end else if (restart) begin
      div_reg <= '0;
    end else if (!freeze) begin
      div_reg <= (div_reg == LAST) ? '0 : div_reg + 1'b1;
    end
  end
  // tick on the last clock of each interval
  assign tick = !restart && !freeze && (div_reg == LAST);
endmodule // swdt_prescale

// >>> verilog/swdt_top.sv
// supervisory watchdog timer with apb register access
`timescale 1ns/100ps
module swdt_top
  import swdt_pkg::*;
#(
  parameter int STEP_CLKS = swdt_pkg::SWDT_STEP_CLKS,
  parameter int RST_PULSE_CLKS = swdt_pkg::SWDT_RST_PULSE_CLKS
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic activationSourceOption,
  input wire logic stopPinControlOption,
  input wire logic stopPermitPin,
  input wire swdt_pkg::swdt_mode_t cpuModeReq,
  input wire logic exitStop,
  output swdt_pkg::swdt_mode_t cpuMode,
  output logic resetPinOutN,
  output logic resetPinOe
);
  import swdt_pkg::*;

  initial begin
    if (STEP_CLKS < 2) $error("swdt_top: STEP_CLKS too small");
    if (RST_PULSE_CLKS < 1) $error("swdt_top: RST_PULSE_CLKS too small");
  end

  localparam int PW = $clog2(RST_PULSE_CLKS + 1);
  // step length check against the reference figure, in microseconds at 8 MHz
  localparam int STEP_US_CHECK = (SWDT_STEP_CLKS * 1000) / (8 * 1000);

  logic [SWDT_TMR_W-1:0] timer_reg; // soft-reset bit on top of six count bits
  logic [SWDT_TMR_W-1:0] timer_next; // next counter value
  logic active_reg; // watchdog activated
  logic hwOpt_reg; // hardware activation strap caught after release
  logic extOpt_reg; // stop pin control strap caught after release
  logic strapDone_reg; // straps captured
  logic stopped_reg; // counter frozen in stop mode
  logic [PW-1:0] pulse_reg; // remaining reset pulse clocks
  logic permitSync; // synchronised stop-permit pin
  logic stepTick; // step interval expired
  logic wrCount; // apb write of the count register
  logic [SWDT_TMR_W-1:0] wrTimer; // counter bits from the write data
  logic wrAct; // write data activate bit
  logic fire; // start of a reset cycle
  swdt_mode_t cpuMode_next; // mode granted to the core
  logic [7:0] countView; // register image of the counter
  logic activeNow; // activation in force this cycle, strap included before capture
  logic extNow; // pin control option in force this cycle

  initial begin
    if (STEP_US_CHECK != SWDT_STEP_US_8MHZ) $error("swdt_top: step time mismatch");
  end

  // stop-permit pin through the synchroniser
  swdt_sync u_sync (
    .mclk(mclk),
    .rstn(rstn),
    .pinIn(stopPermitPin),
    .pinOut(permitSync)
  );

  // step prescaler, restarted by writes, frozen in stop
  swdt_prescale #(
    .STEP_CLKS(STEP_CLKS)
  ) u_pre (
    .mclk(mclk),
    .rstn(rstn),
    .restart(wrCount),
    .freeze(stopped_reg),
    .tick(stepTick)
  );

  // apb decode: zero-wait answer, low byte lane carries the register
  assign pready = 1'b1;
  assign pslverr = psel && penable &&
    !(paddr == SWDT_COUNT_OFS || paddr == SWDT_CFG_OFS || paddr == SWDT_STAT_OFS);
  assign wrCount = psel && penable && pwrite && pstrb[0] && (paddr == SWDT_COUNT_OFS);

  // unreverse the written count bits; bit 7 is the counter lsb
  always_comb begin
    wrTimer = '0;
    for (int i = 0; i < SWDT_CNT_W; i++) begin
      wrTimer[i] = pwdata[7 - i];
    end
    wrTimer[SWDT_CNT_W] = pwdata[SWDT_SRST_BIT];
    wrAct = pwdata[SWDT_ACT_BIT];
  end

  // register image: reversed count bits, soft-reset, activate
  always_comb begin
    countView = '0;
    for (int i = 0; i < SWDT_CNT_W; i++) begin
      countView[7 - i] = timer_reg[i];
    end
    countView[SWDT_SRST_BIT] = timer_reg[SWDT_CNT_W];
    countView[SWDT_ACT_BIT] = active_reg;
  end

  // the strap acts from the first clock after release, before it is captured,
  // so a hardware-activated watchdog is never inactive for even one cycle
  assign activeNow = active_reg || (!strapDone_reg && activationSourceOption);
  assign extNow = strapDone_reg ? extOpt_reg : stopPinControlOption;

  // catch the option straps one clock after reset release
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hwOpt_reg <= 1'b0;
      extOpt_reg <= 1'b0;
      strapDone_reg <= 1'b0;
    end else if (!strapDone_reg) begin
      hwOpt_reg <= activationSourceOption;
      extOpt_reg <= stopPinControlOption;
      strapDone_reg <= 1'b1;
    end
  end

  // activation: forced by strap, or set once by software, never cleared
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      active_reg <= SWDT_RESET_VAL[SWDT_ACT_BIT];
    end else if (!strapDone_reg && activationSourceOption) begin
      active_reg <= 1'b1;
    end else if (hwOpt_reg) begin
      active_reg <= 1'b1;
    end else if (wrCount && wrAct) begin
      active_reg <= 1'b1;
    end
  end

  // next counter value: write wins, else one step down per tick
  always_comb begin
    timer_next = timer_reg;
    if (wrCount) begin
      timer_next = wrTimer;
    end else if (stepTick) begin
      timer_next = timer_reg - 1'b1;
    end
  end

  // counter register; wraps from zero to maximum, active or not
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      timer_reg <= {SWDT_RESET_VAL[SWDT_SRST_BIT], SWDT_RESET_VAL[2], SWDT_RESET_VAL[3],
        SWDT_RESET_VAL[4], SWDT_RESET_VAL[5], SWDT_RESET_VAL[6], SWDT_RESET_VAL[7]};
    end else begin
      timer_reg <= timer_next;
    end
  end

  // soft-reset bit falls while active: start a reset cycle
  assign fire = (activeNow || (wrCount && wrAct)) && timer_reg[SWDT_CNT_W] &&
    !timer_next[SWDT_CNT_W] && (pulse_reg == '0);

  // reset pulse counter holding the pin low
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pulse_reg <= '0;
    end else if (fire) begin
      pulse_reg <= PW'(RST_PULSE_CLKS);
    end else if (pulse_reg != '0) begin
      pulse_reg <= pulse_reg - 1'b1;
    end
  end

  // open-drain reset pin: enable low while pulling low
  assign resetPinOutN = 1'b0;
  assign resetPinOe = (pulse_reg == '0);

  // power mode decision for a stop request
  always_comb begin
    cpuMode_next = cpuModeReq;
    if (cpuModeReq == SWDT_STOP) begin
      if (!activeNow) begin
        cpuMode_next = SWDT_STOP;
      end else if (!extNow) begin
        cpuMode_next = SWDT_WAIT;
      end else if (!permitSync) begin
        cpuMode_next = SWDT_WAIT;
      end else begin
        cpuMode_next = SWDT_STOP;
      end
    end
  end

  // granted mode; stop exit on interrupt returns to run
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cpuMode <= SWDT_RUN;
    end else if (exitStop) begin
      cpuMode <= SWDT_RUN;
    end else begin
      cpuMode <= cpuMode_next;
    end
  end

  // counter freeze in stop; released only when exitStop is raised, not when the core leaves stop otherwise
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stopped_reg <= 1'b0;
    end else if (exitStop) begin
      stopped_reg <= 1'b0;
    end else if (cpuModeReq == SWDT_STOP && activeNow && extNow && permitSync) begin
      stopped_reg <= 1'b1;
    end else if (cpuModeReq == SWDT_STOP && !activeNow) begin
      stopped_reg <= 1'b1;
    end
  end

  // read data register, captured in the setup phase
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        SWDT_COUNT_OFS: prdata <= {24'h000000, countView};
        SWDT_CFG_OFS: prdata <= {28'h0000000, stopped_reg, permitSync, extOpt_reg, hwOpt_reg};
        SWDT_STAT_OFS: prdata <= {16'h0000, 7'h00, (pulse_reg != '0), 1'b0, timer_reg};
        default: prdata <= '0;
      endcase
    end
  end
endmodule // swdt_top

// >>> test/swdt_top_checker.sv
// checker: port-level timing of the supervisory timer
`timescale 1ns/100ps
module swdt_top_checker
  import swdt_pkg::*;
#(
  parameter int STEP_CLKS = 3072,
  parameter int RST_PULSE_CLKS = 125
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic activationSourceOption,
  input wire logic stopPinControlOption,
  input wire logic stopPermitPin,
  input wire swdt_pkg::swdt_mode_t cpuModeReq,
  input wire logic exitStop,
  input wire swdt_pkg::swdt_mode_t cpuMode,
  input wire logic resetPinOutN,
  input wire logic resetPinOe
);
  logic acc; // access phase of a transfer
  int lowCnt; // cycles the reset pin has been pulled so far
  int pinLowCnt; // cycles the stop-permit pin has stood low, saturating at 8
  assign acc = psel && penable;
  // the synchroniser reads low after reset, so the count starts saturated
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pinLowCnt <= 8;
    end else if (stopPermitPin) begin
      pinLowCnt <= 0;
    end else if (pinLowCnt < 8) begin
      pinLowCnt <= pinLowCnt + 1;
    end
  end
  // count pulled cycles, cleared when the pin is let go
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) lowCnt <= 0;
    else lowCnt <= resetPinOe ? 0 : lowCnt + 1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  pulse_len_a: assert property ($rose(resetPinOe) |-> lowCnt == RST_PULSE_CLKS)
    else $error("reset pulse length off");
  pulse_cause_a: assert property (acc && pwrite && pstrb[0] && paddr == 12'h000
    && pwdata[1:0] == 2'b01 |-> ##[1:2] !resetPinOe) else $error("no soft reset pulse");
  unmapped_err_a: assert property (acc && !pwrite && !(paddr inside {12'h000, 12'h004,
    12'h008}) |-> pslverr && prdata == 32'h0) else $error("unmapped read not refused");
  mapped_ok_a: assert property (acc && paddr == 12'h000 |-> !pslverr && prdata[31:8] == 24'h0)
    else $error("count register access refused");
  hw_forced_a: assert property (acc && !pwrite && paddr == 12'h000
    && activationSourceOption |-> prdata[0]) else $error("activate bit not forced");
  stop_wait_a: assert property (activationSourceOption && !stopPinControlOption
    && $past(cpuModeReq) == SWDT_STOP |-> cpuMode != SWDT_STOP) else $error("stop granted");
  wait_grant_a: assert property (cpuModeReq == SWDT_WAIT ##1 cpuModeReq == SWDT_WAIT
    |-> cpuMode == SWDT_WAIT) else $error("wait not granted");
  hw_pin_low_a: assert property (activationSourceOption && pinLowCnt >= 6
    && $past(cpuModeReq) == SWDT_STOP |-> cpuMode != SWDT_STOP)
    else $error("stop granted while permit pin low");
  drive_const_a: assert property (!resetPinOutN && pready)
    else $error("pin data or ready wrong");
endmodule // swdt_top_checker
bind swdt_top swdt_top_checker #(.STEP_CLKS(STEP_CLKS), .RST_PULSE_CLKS(RST_PULSE_CLKS))
  swdt_top_checker_i (.*);

// >>> test/swdt_cpu_model.sv
// core model: apb master through which software reaches the count register
`timescale 1ns/100ps
module swdt_cpu_model (
  input wire logic mclk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb
);
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
  end
  // one transfer: setup, then access held until ready is seen at an edge
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] d,
    output logic [31:0] q);
    int k = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = (pready === 1'b1) ? prdata : 32'hX;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // read twice, and a third time if the two differ, since a read may meet a decrement
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic [31:0] p;
    xfer(1'b0, a, 8'h00, p);
    xfer(1'b0, a, 8'h00, q);
    if (q !== p) xfer(1'b0, a, 8'h00, q);
  endtask
endmodule // swdt_cpu_model

// >>> test/swdt_top_tb.sv
// testbench: register table, countdown, reset pulse and power modes
`timescale 1ns/100ps
module swdt_top_tb;
  import swdt_pkg::*;
  localparam int PULSE = 4; // shortened reset pulse
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, resetPinOutN, resetPinOe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] pstrb;
  logic activationSourceOption = 1'b0; // strap: hardware activation
  logic stopPinControlOption = 1'b0; // strap: pin-controlled stop
  logic stopPermitPin = 1'b0; // stop-permit pin
  logic exitStop = 1'b0; // interrupt leaving stop
  swdt_mode_t cpuModeReq = SWDT_RUN;
  swdt_mode_t cpuMode;
  int fails = 0;
  int nCompared = 0;
  int n;
  // rows: address, byte written, byte read back
  logic [27:0] rows [5] = '{28'h000FCFC, 28'h0000202, 28'h0008080, 28'h0007C7C, 28'h010A500};
  swdt_top #(.STEP_CLKS(16), .RST_PULSE_CLKS(PULSE)) swdt_top_i (.*);
  swdt_cpu_model swdt_cpu_model_i (.*);
  always #2 mclk = ~mclk;
  task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  task automatic chkMode(input swdt_mode_t got, input swdt_mode_t exp);
    chkReg({30'h0, got}, {30'h0, exp});
  endtask
  task automatic rdChk(input logic [7:0] e);
    swdt_cpu_model_i.rd(12'h000, q);
    chkReg(q, {24'h0, e});
  endtask
  task automatic wr(input logic [7:0] d);
    swdt_cpu_model_i.xfer(1'b1, 12'h000, d, q);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask
  task automatic doReset(input logic hw, input logic ext);
    rstn <= 1'b0;
    activationSourceOption <= hw;
    stopPinControlOption <= ext;
    cyc(5);
    rstn <= 1'b1;
    cyc(2);
  endtask
  // wait for the pin to be pulled, then measure how long
  task automatic pulse(input int bound);
    n = 0;
    while (resetPinOe !== 1'b0 && n < bound) begin
      @(negedge mclk);
      n++;
    end
    n = 0;
    while (resetPinOe === 1'b0 && n < 50) begin
      @(negedge mclk);
      n++;
    end
    chkReg(32'(n), 32'(PULSE));
  endtask
  task automatic stop_test;
    $display("compared %0d, mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // cut a hang short
  initial begin
    cyc(20000);
    fails++;
    stop_test;
  end
  initial begin
    doReset(1'b0, 1'b0);
    rdChk(8'hFE);
    for (int i = 0; i < 5; i++) begin
      swdt_cpu_model_i.xfer(1'b1, rows[i][27:16], rows[i][15:8], q);
      swdt_cpu_model_i.rd(rows[i][27:16], q);
      chkReg(q, {24'h0, rows[i][7:0]});
      chkReg({31'h0, resetPinOe}, 32'h1);
    end
    $display("table done");
    cpuModeReq <= SWDT_WAIT;
    wr(8'h82);
    cyc(10);
    rdChk(8'h82);
    cyc(6);
    rdChk(8'h02);
    cpuModeReq <= SWDT_RUN;
    wr(8'h00);
    cyc(20);
    rdChk(8'hFE);
    wr(8'hFF);
    wr(8'hFE);
    rdChk(8'hFF);
    wr(8'hFD);
    pulse(10);
    wr(8'h83);
    pulse(60);
    $display("countdown and pulse done");
    doReset(1'b0, 1'b0);
    wr(8'h82);
    cpuModeReq <= SWDT_STOP;
    cyc(30);
    chkMode(cpuMode, SWDT_STOP);
    cpuModeReq <= SWDT_RUN;
    exitStop <= 1'b1;
    cyc(1);
    exitStop <= 1'b0;
    rdChk(8'h82);
    cyc(14);
    rdChk(8'h02);
    doReset(1'b1, 1'b0);
    rdChk(8'hFF);
    wr(8'hFE);
    rdChk(8'hFF);
    cpuModeReq <= SWDT_STOP;
    cyc(6);
    chkMode(cpuMode, SWDT_WAIT);
    doReset(1'b1, 1'b1);
    cyc(6);
    chkMode(cpuMode, SWDT_WAIT);
    cpuModeReq <= SWDT_RUN;
    stopPermitPin <= 1'b1;
    cyc(6);
    cpuModeReq <= SWDT_STOP;
    cyc(6);
    chkMode(cpuMode, SWDT_STOP);
    $display("power modes done");
    stop_test;
  end
endmodule // swdt_top_tb
